// [rtl/ppd_consts.vh]
`ifndef PPD_CONSTS_VH
`define PPD_CONSTS_VH

// ----------------------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------------------
`define PPD_OP_ARITH       2'h2
`define PPD_OP_MEM         2'h3
`define PPD_OPC_POPCOUNT   6'h2e
`define PPD_OPC_HINT       6'h2d
`define PPD_OPC_HINT_ALT   6'h3d

// ----------------------------------------------------------------------------
// Function codes
// ----------------------------------------------------------------------------
`define PPD_FCN_PAGE       5'h04
`define PPD_FCN_RSV_LO     5'h05
`define PPD_FCN_RSV_HI     5'h0f
`define PPD_FCN_UNIFIED    5'h11
`define PPD_FCN_STRONG_LO  5'h14
`define PPD_FCN_STRONG_HI  5'h17

// ----------------------------------------------------------------------------
// Address space identifiers
// ----------------------------------------------------------------------------
`define PPD_ASI_PRIMARY    8'h80
`define PPD_ASI_PRIMARY_LE 8'h88
`define PPD_ASI_PRIV_LO    8'h30
`define PPD_ASI_USER_HI    8'h7f

// ----------------------------------------------------------------------------
// Register map, AXI4-Lite byte addresses
// ----------------------------------------------------------------------------
`define PPD_REG_CTRL       4'h0
`define PPD_REG_ASI        4'h4
`define PPD_REG_STAT       4'h8
`define PPD_REG_COUNT      4'hc
`define PPD_CTRL_RESET     32'h0000000f
`define PPD_ASI_RESET      8'h80
`define PPD_BLOCK_BYTES    64
`define PPD_RESP_OKAY      2'h0
`define PPD_RESP_SLVERR    2'h2

`endif

// [rtl/ppd_popcount_prefetch_decode.v]
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/100ps
// What this block does
// - Popcount of second source or sign-extended immediate
// - Popcount leaves both condition code sets
// - Popcount always counts all 64 bits
// - Popcount traps on nonzero 18:14, or nonzero 12:5 register form
// - Recognise primary and alternate hint opcodes
// - Function code selects weak, page, unified, strong
// - Reserved codes 5 to 15 trap
// - Unimplemented implementation codes act as no-op
// - Address is first source plus second or immediate
// - Primary hint uses primary space, big-endian 80 only
// - Alternate space from field or state register
// - Pipeline never stalls on a hint
// - Hint observable as no-op, never address traps
// - Fetched block at least 64 bytes aligned
// - Implemented hint starts block or translation move
// - Each variant: no-op, full or simple
// - Primary hint traps on nonzero 12:5 register form
// - Bad or privileged-barred space completes as no-op
// - Weak hint abandons when slow, strong continues
`include "ppd_consts.vh"

module ppd_popcount_prefetch_decode #(
	parameter ADDR_W = 64
)(
	input  wire              core_clk,
	input  wire              arst_n,
	input  wire              issue_valid,
	input  wire [31:0]       instr_word,
	input  wire [63:0]       first_source_register,
	input  wire [63:0]       second_source_register,
	input  wire              priv_mode,
	input  wire              slow_path,
	input  wire              mem_req_ready,
	output reg               result_valid,
	output reg  [4:0]        result_dest,
	output reg  [63:0]       result_data,
	output reg               illegal_trap,
	output reg               hint_done,
	output reg               cc_write,
	output reg               issue_stall,
	output reg               mem_req_valid,
	output reg  [ADDR_W-1:0] mem_req_addr,
	output reg  [7:0]        mem_req_asi,
	output reg  [4:0]        mem_req_fcn,
	output reg               mem_req_tlb,
	output reg               mem_req_strong,
	input  wire [31:0]       s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output reg               s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output reg               s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [31:0]       s_axi_araddr,
	input  wire              s_axi_arvalid,
	output reg               s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready
);

	// ------------------------------------------------------------------------
	// Field extraction
	// ------------------------------------------------------------------------
	wire [1:0]  op_major             = instr_word[31:30];
	wire [4:0]  dest_fcn             = instr_word[29:25];
	wire [5:0]  operation_code_field = instr_word[24:19];
	wire [4:0]  src1_field           = instr_word[18:14];
	wire        imm_sel              = instr_word[13];
	wire [7:0]  imm_space_field      = instr_word[12:5];
	wire [63:0] signed_13bit_immediate = {{51{instr_word[12]}}, instr_word[12:0]};

	reg  [31:0] ctrl_r;
	reg  [7:0]  asi_state_r;
	reg  [31:0] issued_cnt_r;
	reg  [31:0] dropped_cnt_r;
	reg         last_trap_r;

	// Control bits: 0 weak enable, 1 page enable, 2 unified enable, 3 strong enable.
	wire        en_weak    = ctrl_r[0];
	wire        en_page    = ctrl_r[1];
	wire        en_unified = ctrl_r[2];
	wire        en_strong  = ctrl_r[3];

	// ------------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------------
	wire is_popc   = issue_valid && op_major == `PPD_OP_ARITH && operation_code_field == `PPD_OPC_POPCOUNT;
	wire is_pf     = issue_valid && op_major == `PPD_OP_MEM && operation_code_field == `PPD_OPC_HINT;
	wire is_pf_alt = issue_valid && op_major == `PPD_OP_MEM && operation_code_field == `PPD_OPC_HINT_ALT;
	wire any_pf    = is_pf || is_pf_alt;

	wire popc_bad  = (src1_field != 5'h00) || (!imm_sel && imm_space_field != 8'h00);
	wire fcn_rsv   = dest_fcn >= `PPD_FCN_RSV_LO && dest_fcn <= `PPD_FCN_RSV_HI;
	wire pf_bad    = fcn_rsv || (is_pf && !imm_sel && imm_space_field != 8'h00);

	// full 64-bit population count, no 32-bit variant.
	wire [63:0] popc_src = imm_sel ? signed_13bit_immediate : second_source_register;
	reg  [6:0]  popc_sum;
	integer     k;
	always @*
	begin
		popc_sum = 7'h00;
		for (k = 0; k < 64; k = k + 1)
			popc_sum = popc_sum + {6'h00, popc_src[k]};
	end

	wire [63:0] eff_addr = first_source_register + (imm_sel ? signed_13bit_immediate : second_source_register);

	// space selection; little-endian primary is bit 3 of the stored identifier.
	wire [7:0] alt_space = imm_sel ? asi_state_r : imm_space_field;
	wire [7:0] pf_space  = is_pf ? `PPD_ASI_PRIMARY : alt_space;

	// permitted spaces are nucleus, as-if-user, primary, secondary, no-fault, real.
	reg space_ok;
	always @*
	begin
		case (pf_space & 8'hf7)
			8'h04, 8'h10, 8'h11, 8'h14, 8'h80, 8'h81, 8'h82, 8'h83: space_ok = 1'b1;
			default: space_ok = 1'b0;
		endcase
	end
	wire space_barred = !priv_mode ? (pf_space <= `PPD_ASI_USER_HI)
	                               : (pf_space >= `PPD_ASI_PRIV_LO && pf_space <= `PPD_ASI_USER_HI);

	// per-variant implementation choice from the control register.
	wire fcn_weak   = dest_fcn <= 5'h03;
	wire fcn_strong = dest_fcn >= `PPD_FCN_STRONG_LO && dest_fcn <= `PPD_FCN_STRONG_HI;
	wire fcn_impl   = (fcn_weak && en_weak) || (dest_fcn == `PPD_FCN_PAGE && en_page) ||
	                  (dest_fcn == `PPD_FCN_UNIFIED && en_unified) || (fcn_strong && en_strong);

	// weak hints drop when the memory side signals a slow path; strong ones continue.
	wire weak_drop = fcn_weak && slow_path;
	wire pf_go     = any_pf && !pf_bad && fcn_impl && !weak_drop &&
	                 (is_pf || (space_ok && !space_barred));

	// ------------------------------------------------------------------------
	// Pipeline side
	// ------------------------------------------------------------------------
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			result_valid   <= 1'b0;
			result_dest    <= 5'h00;
			result_data    <= 64'h0;
			illegal_trap   <= 1'b0;
			hint_done      <= 1'b0;
			cc_write       <= 1'b0;
			issue_stall    <= 1'b0;
			mem_req_valid  <= 1'b0;
			mem_req_addr   <= {ADDR_W{1'b0}};
			mem_req_asi    <= 8'h00;
			mem_req_fcn    <= 5'h00;
			mem_req_tlb    <= 1'b0;
			mem_req_strong <= 1'b0;
			issued_cnt_r   <= 32'h0;
			dropped_cnt_r  <= 32'h0;
			last_trap_r    <= 1'b0;
		end
		else
		begin
			cc_write     <= 1'b0;
			issue_stall  <= 1'b0;
			result_valid <= is_popc && !popc_bad;
			result_dest  <= dest_fcn;
			result_data  <= {57'h0, popc_sum};
			illegal_trap <= (is_popc && popc_bad) || (any_pf && pf_bad);
			hint_done    <= any_pf && !pf_bad;
			if (is_popc || any_pf)
				last_trap_r <= (is_popc && popc_bad) || (any_pf && pf_bad);
			// A request the memory side has not yet taken is replaced, never waited for.
			if (pf_go)
			begin
				mem_req_valid  <= 1'b1;
				mem_req_addr   <= {eff_addr[ADDR_W-1:6], 6'h00};
				mem_req_asi    <= pf_space;
				mem_req_fcn    <= dest_fcn;
				mem_req_tlb    <= dest_fcn == `PPD_FCN_PAGE;
				mem_req_strong <= fcn_strong;
				issued_cnt_r   <= issued_cnt_r + 32'h1;
			end
			else
			begin
				if (mem_req_ready)
					mem_req_valid <= 1'b0;
				if (any_pf && !pf_bad)
					dropped_cnt_r <= dropped_cnt_r + 32'h1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------------------
	reg        aw_hold_r;
	reg        w_hold_r;
	reg [3:0]  aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0]  w_strb_r;
	wire       aw_take = s_axi_awvalid && s_axi_awready;
	wire       w_take  = s_axi_wvalid && s_axi_wready;
	wire       aw_have = aw_hold_r || aw_take;
	wire       w_have  = w_hold_r || w_take;
	wire [3:0] wa      = aw_take ? s_axi_awaddr[3:0] : aw_addr_r;
	wire [31:0] wd     = w_take ? s_axi_wdata : w_data_r;
	wire [3:0] ws      = w_take ? s_axi_wstrb : w_strb_r;
	wire       do_wr   = aw_have && w_have && !s_axi_bvalid;
	wire       wr_hit  = s_axi_awaddr[31:4] == 28'h0;
	reg        wr_hit_r;
	wire       wa_hit  = aw_take ? wr_hit : wr_hit_r;

	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PPD_RESP_OKAY;
			aw_hold_r     <= 1'b0;
			w_hold_r      <= 1'b0;
			aw_addr_r     <= 4'h0;
			wr_hit_r      <= 1'b0;
			w_data_r      <= 32'h0;
			w_strb_r      <= 4'h0;
			ctrl_r        <= `PPD_CTRL_RESET;
			asi_state_r   <= `PPD_ASI_RESET;
		end
		else
		begin
			if (aw_take)
			begin
				aw_addr_r     <= s_axi_awaddr[3:0];
				wr_hit_r      <= wr_hit;
				s_axi_awready <= 1'b0;
			end
			if (w_take)
			begin
				w_data_r     <= s_axi_wdata;
				w_strb_r     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			aw_hold_r <= aw_have && !do_wr;
			w_hold_r  <= w_have && !do_wr;
			if (do_wr)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `PPD_RESP_OKAY;
				if (wa_hit && wa == `PPD_REG_CTRL && ws[0])
					ctrl_r[3:0] <= wd[3:0];
				else if (wa_hit && wa == `PPD_REG_ASI && ws[0])
					asi_state_r <= wd[7:0];
				else if (!(wa_hit && (wa == `PPD_REG_CTRL || wa == `PPD_REG_ASI)))
					s_axi_bresp <= `PPD_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Reads return after one cycle; the status word shows the last decode outcome.
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `PPD_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `PPD_RESP_OKAY;
			s_axi_rdata   <= 32'h0;
			if (s_axi_araddr[31:4] != 28'h0)
				s_axi_rresp <= `PPD_RESP_SLVERR;
			else
				case (s_axi_araddr[3:0])
					`PPD_REG_CTRL:  s_axi_rdata <= {28'h0, ctrl_r[3:0]};
					`PPD_REG_ASI:   s_axi_rdata <= {24'h0, asi_state_r};
					`PPD_REG_STAT:  s_axi_rdata <= {dropped_cnt_r[15:0], 14'h0, mem_req_valid, last_trap_r};
					`PPD_REG_COUNT: s_axi_rdata <= issued_cnt_r;
					default:        s_axi_rresp <= `PPD_RESP_SLVERR;
				endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule // ppd_popcount_prefetch_decode

// [bench/ppd_mem_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Memory side of the hint request port
// ----------------------------------------
module ppd_mem_model(
	input	wire	core_clk,
	input	wire	arst_n,
	input	wire	slow,
	output	reg	mem_req_ready
);
	reg	[1:0]	cnt_r;
	// When slow, only one cycle in four takes a request, so requests stand and get replaced.
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_r <= 2'h0;
			mem_req_ready <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_r + 2'h1;
			mem_req_ready <= !slow || cnt_r == 2'h3;
		end
	end
endmodule // ppd_mem_model

// [bench/ppd_chk.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module ppd_chk #(parameter ADDR_W = 64)(
	input	wire			core_clk,
	input	wire			arst_n,
	input	wire			issue_valid,
	input	wire	[31:0]		instr_word,
	input	wire	[63:0]		second_source_register,
	input	wire			result_valid,
	input	wire	[63:0]		result_data,
	input	wire			illegal_trap,
	input	wire			hint_done,
	input	wire			cc_write,
	input	wire			issue_stall,
	input	wire			mem_req_valid,
	input	wire			mem_req_ready,
	input	wire	[ADDR_W-1:0]	mem_req_addr,
	input	wire	[7:0]		mem_req_asi
);
	wire		popc = issue_valid && instr_word[31:30] == 2'h2 && instr_word[24:19] == 6'h2e;
	wire		hint = issue_valid && instr_word[31:30] == 2'h3 && instr_word[24] && instr_word[22:19] == 4'hd;
	wire		prim = hint && !instr_word[23];
	wire	[4:0]	fcn = instr_word[29:25];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	AST_NO_CC: assert property (!cc_write) else $error("condition codes written");
	AST_NO_STALL: assert property (!issue_stall) else $error("pipeline stalled");
	AST_ONE_ANSWER: assert property ($onehot0({result_valid, illegal_trap, hint_done})) else $error("two answers");
	AST_POPC_CNT: assert property (popc && instr_word[18:5] == 14'h0 |=> result_valid && result_data ==
		64'($countones($past(second_source_register)))) else $error("count wrong");
	AST_POPC_TRAP: assert property (popc && instr_word[18:14] != 5'h0 |=> illegal_trap && !result_valid)
		else $error("popc not trapped");
	AST_RSV_TRAP: assert property (hint && fcn inside {[5:15]} |=> illegal_trap && !hint_done)
		else $error("reserved code not trapped");
	AST_PRIM_TRAP: assert property (prim && !instr_word[13] && instr_word[12:5] != 8'h0 |=> illegal_trap)
		else $error("primary hint not trapped");
	AST_HINT_OK: assert property (hint && instr_word[13] && !(fcn inside {[5:15]}) |=>
		hint_done && !illegal_trap) else $error("hint trapped");
	AST_ALIGN: assert property (mem_req_valid |-> mem_req_addr[5:0] == 6'h0) else $error("block unaligned");
	AST_PRIM_ASI: assert property (prim && instr_word[13] && fcn == 5'h4 |=>
		mem_req_valid && mem_req_asi == 8'h80) else $error("primary space wrong");
	AST_HOLD: assert property (mem_req_valid && !mem_req_ready && !hint |=>
		mem_req_valid && $stable(mem_req_addr)) else $error("request dropped");
	cover property (result_valid);
	cover property (illegal_trap);
	cover property (mem_req_valid && !mem_req_ready);
endmodule // ppd_chk
bind ppd_popcount_prefetch_decode ppd_chk #(.ADDR_W(ADDR_W)) chk(.core_clk, .arst_n, .issue_valid, .instr_word,
	.second_source_register, .result_valid, .result_data, .illegal_trap, .hint_done, .cc_write, .issue_stall,
	.mem_req_valid, .mem_req_ready, .mem_req_addr, .mem_req_asi);

// [bench/test_popcount_prefetch_decode.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module test_popcount_prefetch_decode;
	reg		core_clk = 0, arst_n = 0, issue_valid = 0, priv_mode = 0, slow_path = 0, slow = 0;
	reg		s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	reg	[31:0]	instr_word = 0, s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, seed = 32'h1ec18e2e, r1, rw;
	reg	[3:0]	s_axi_wstrb = 4'hf, ctl_m = 4'hf;
	reg	[63:0]	first_source_register = 0, second_source_register = 0;
	reg	[7:0]	asi_m = 8'h80;
	integer		n_mismatch = 0, check_count = 0, k, n_req = 0;
	wire		result_valid, illegal_trap, hint_done, cc_write, issue_stall, mem_req_valid, mem_req_ready;
	wire		mem_req_tlb, mem_req_strong, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire	[4:0]	result_dest, mem_req_fcn;
	wire	[63:0]	result_data, mem_req_addr;
	wire	[7:0]	mem_req_asi;
	wire	[1:0]	s_axi_bresp, s_axi_rresp;
	wire	[31:0]	s_axi_rdata;
	ppd_popcount_prefetch_decode uut(.core_clk, .arst_n, .issue_valid, .instr_word, .first_source_register,
		.second_source_register, .priv_mode, .slow_path, .mem_req_ready, .result_valid, .result_dest, .result_data,
		.illegal_trap, .hint_done, .cc_write, .issue_stall, .mem_req_valid, .mem_req_addr, .mem_req_asi, .mem_req_fcn,
		.mem_req_tlb, .mem_req_strong, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	ppd_mem_model mem(.core_clk, .arst_n, .slow, .mem_req_ready);
	initial forever #20 core_clk = ~core_clk;
	function automatic [31:0] xs(input [31:0] s);
		reg	[31:0]	x;
		begin
			x = s ^ (s << 13);
			x = x ^ (x >> 17);
			xs = x ^ (x << 5);
		end
	endfunction
	task end_sim;
		begin
			$display("checks %0d mismatches %0d", check_count, n_mismatch);
			if (n_mismatch == 0 && check_count > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task chk(input ok);
		begin
			check_count++;
			if (!ok)
			begin
				n_mismatch++;
				$display("BAD %0t mismatch", $time);
			end
		end
	endtask
	// Both bus tasks give up after 50 cycles; a dead slave ends the run instead of hanging it.
	// Each starts one edge on, so a release and the next request never share a time step.
	task axw(input [31:0] ad, dt, input [1:0] er);
		reg	d;
		begin
			d = 0;
			@(posedge core_clk);
			s_axi_awaddr <= ad; s_axi_wdata <= dt; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
			for (k = 0; k < 50 && !d; k++)
			begin
				@(posedge core_clk);
				if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
				if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
				if (s_axi_bvalid)
				begin
					d = 1;
					s_axi_bready <= 0;
					chk(s_axi_bresp === er);
				end
			end
			if (!d) begin chk(1'b0); end_sim; end
		end
	endtask
	task axr(input [31:0] ad, dt, input [1:0] er);
		reg	d;
		begin
			d = 0;
			@(posedge core_clk);
			s_axi_araddr <= ad; s_axi_arvalid <= 1; s_axi_rready <= 1;
			for (k = 0; k < 50 && !d; k++)
			begin
				@(posedge core_clk);
				if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
				if (s_axi_rvalid)
				begin
					d = 1;
					s_axi_rready <= 0;
					chk({s_axi_rdata, s_axi_rresp} === {dt, er});
				end
			end
			if (!d) begin chk(1'b0); end_sim; end
		end
	endtask
	task run(input [31:0] w, input [63:0] a, b, input pv, sl);
		reg	[63:0]	op;
		reg	[7:0]	asi;
		reg	[4:0]	f;
		reg		pop, hnt, trap, req;
		begin
			f = w[29:25];
			op = w[13] ? {{51{w[12]}}, w[12:0]} : b;
			pop = w[31:30] == 2'h2 && w[24:19] == 6'h2e;
			hnt = w[31:30] == 2'h3 && w[24] && w[22:19] == 4'hd;
			asi = !w[23] ? 8'h80 : w[13] ? asi_m : w[12:5];
			trap = pop ? (w[18:14] != 0 || !w[13] && w[12:5] != 0) : hnt && (f >= 5 && f <= 15 || !w[23] && !w[13] && w[12:5] != 0);
			req = hnt && !trap && (f <= 3 && ctl_m[0] || f == 4 && ctl_m[1] || f == 17 && ctl_m[2]
				|| f >= 20 && f <= 23 && ctl_m[3]) && !(sl && f <= 3)
				&& (pv ? !(asi >= 8'h30 && asi <= 8'h7f) : asi >= 8'h80)
				&& (asi & 8'hf7) inside {8'h04, 8'h10, 8'h11, 8'h14, 8'h80, 8'h81, 8'h82, 8'h83};
			@(posedge core_clk);
			instr_word <= w; first_source_register <= a; second_source_register <= b;
			priv_mode <= pv; slow_path <= sl; issue_valid <= 1;
			@(posedge core_clk);
			issue_valid <= 0;
			#1;
			chk({result_valid, illegal_trap, hint_done} === {pop && !trap, trap, hnt && !trap});
			if (pop && !trap) chk({result_data, result_dest} === {64'($countones(op)), f});
			if (req) chk({mem_req_valid, mem_req_addr, mem_req_asi, mem_req_fcn, mem_req_tlb, mem_req_strong} ===
				{1'b1, (a + op) & ~64'h3f, asi, f, f == 5'h4, f >= 20 && f <= 23});
			if (req)
				n_req = n_req + 1;
		end
	endtask
	initial
	begin
		repeat (4) @(posedge core_clk);
		arst_n <= 1;
		@(posedge core_clk);
		axr(32'h0, 32'hf, 2'h0);
		axr(32'h4, 32'h80, 2'h0);
		axr(32'h10, 32'h0, 2'h2);
		axw(32'h20, 32'h1, 2'h2);
		axw(32'h4, 32'h14, 2'h0);
		axr(32'h4, 32'h14, 2'h0);
		asi_m = 8'h14;
		$display("test registers done");
		for (r1 = 0; r1 < 32; r1++) run({2'h3, r1[4:0], 19'h5a080, 6'h0}, 64'h1234, 0, 1, 0);
		$display("test codes done");
		for (r1 = 0; r1 < 600; r1++)
		begin
			seed = xs(seed);
			rw = seed;
			seed = xs(seed);
			if (r1[5:0] == 0)
			begin
				asi_m = seed[15:8];
				// Page hints stay enabled, since the checker expects every immediate-form primary page hint to issue.
				ctl_m = {seed[20:19], 1'b1, seed[18]};
				axw(32'h4, {24'h0, asi_m}, 2'h0);
				axw(32'h0, {28'h0, ctl_m}, 2'h0);
				axr(32'h0, {28'h0, ctl_m}, 2'h0);
			end
			slow <= seed[7];
			run({seed[0] ? 2'h3 : 2'h2, rw[29:25], seed[2:1] == 0 ? 6'h2e : seed[1] ? 6'h2d : 6'h3d,
				seed[4:3] != 0 ? 5'h0 : rw[18:14], rw[13],
				seed[5] ? 8'h0 : seed[6] ? seed[15:8] & 8'h8b : rw[12:5], rw[4:0]},
				{seed, rw}, {rw, seed}, seed[16], seed[17]);
		end
		axr(32'hc, n_req, 2'h0);
		$display("test random done");
		end_sim;
	end
endmodule // test_popcount_prefetch_decode
